// [hw/marker_block_transfer_pkg.sv]
// Constants, register map and types of the marker block transfer engine.
// Assumes one 125 MHz clock and a plain strobe register port.
//
// Contract
// - Copy mode moves byte_count bytes from the source to the destination.
// - Fill mode writes the one source byte into every destination byte.
// - A word or dword fill source contributes only its lowest byte.
// - count_overflow_error rises when byte_count exceeds a range extent.
// - range_overlap_error rises when source and destination overlap.
// - out_of_range_error rises on a range past memory or a zero count.
// - The error checks run every cycle, trigger edge or not.
// - No destination byte is written while any error holds.
// - With enable required the block acts only while enable is high.
// - Restart clears every register; the marker byte memory keeps its contents.
// - Offsets count from the first marker byte, zero being that byte.
// - A transfer starts on a rising trigger edge, not on its level.
// - Every transfer works byte by byte.
package marker_block_transfer_pkg;

    localparam int OFF_W  = 16;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 12;
    localparam int BYTE_W = 8;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] CTRL_ADDR   = 12'h000;
    localparam logic [ADDR_W-1:0] SRC_ADDR    = 12'h004;
    localparam logic [ADDR_W-1:0] DST_ADDR    = 12'h008;
    localparam logic [ADDR_W-1:0] COUNT_ADDR  = 12'h00c;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h010;
    localparam logic [ADDR_W-1:0] MEM_BASE    = 12'h800;

    // Control fields
    localparam int CTRL_MODE_BIT  = 0;
    localparam int CTRL_WIDTH_LSB = 1;
    localparam int CTRL_ENREQ_BIT = 3;

    // Status fields
    localparam int STAT_OVF_BIT  = 0;
    localparam int STAT_OVL_BIT  = 1;
    localparam int STAT_OOR_BIT  = 2;
    localparam int STAT_BUSY_BIT = 3;

    // Limits and reset values
    localparam logic [OFF_W-1:0]  MAX_COUNT     = 16'h017f;
    localparam logic [OFF_W-1:0]  ZERO_OFF      = 16'h0000;
    localparam logic [OFF_W-1:0]  ONE_OFF       = 16'h0001;
    localparam logic [DATA_W-1:0] ZERO_DATA     = 16'h0000;
    localparam logic [BYTE_W-1:0] ZERO_BYTE     = 8'h00;

    typedef enum logic [1:0] {
        SRC_BYTE  = 2'h0,
        SRC_WORD  = 2'h1,
        SRC_DWORD = 2'h2
    } src_width_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOAD = 3'b010,
        ST_MOVE = 3'b100
    } xfer_state_t;

endpackage

// [hw/range_check.sv]
// Parameter checker of the block transfer engine: three error conditions.
// Assumes stable offset and count inputs; purely combinational.
module range_check
    import marker_block_transfer_pkg::*;
#(
    parameter int MEM_BYTES = 1024
) (
    input  wire logic [OFF_W-1:0] source_offset_i,
    input  wire logic [OFF_W-1:0] dest_offset_i,
    input  wire logic [OFF_W-1:0] byte_count_i,
    input  wire logic             fill_mode_i,
    input  wire src_width_t       src_width_i,
    output logic                  count_overflow_o,
    output logic                  range_overlap_o,
    output logic                  out_of_range_o
);

    localparam logic [OFF_W:0] MEM_LIMIT = (OFF_W+1)'(MEM_BYTES);

    // Bytes covered by a fill source operand
    function automatic logic [OFF_W-1:0] width_bytes(input src_width_t w);
        case (w)
            SRC_WORD:  width_bytes = 16'h0002;
            SRC_DWORD: width_bytes = 16'h0004;
            default:   width_bytes = 16'h0001;
        endcase
    endfunction

    logic [OFF_W-1:0] src_len;
    logic [OFF_W:0]   src_end;
    logic [OFF_W:0]   dst_end;
    logic             zero_count;

    // Fill source spans its operand only, copy source spans the count
    assign src_len    = fill_mode_i ? width_bytes(src_width_i) : byte_count_i;
    assign src_end    = {1'b0, source_offset_i} + {1'b0, src_len};
    assign dst_end    = {1'b0, dest_offset_i} + {1'b0, byte_count_i};
    assign zero_count = (byte_count_i == ZERO_OFF);

    // Count above the per-range limit
    assign count_overflow_o = (byte_count_i > MAX_COUNT);
    // Half-open intervals intersect
    assign range_overlap_o  = !zero_count
                            && ({1'b0, source_offset_i} < dst_end)
                            && ({1'b0, dest_offset_i} < src_end);
    // Past the marker memory, or nothing to move
    assign out_of_range_o   = zero_count
                            || (src_end > MEM_LIMIT)
                            || (dst_end > MEM_LIMIT);

endmodule

// [hw/marker_block_transfer.sv]
// Top of the marker block transfer engine: marker byte memory, register
// port, trigger edge detection and the byte mover.
// Assumes trigger and enable synchronous to clk_i; the register master
// never issues read and write strobes together.
//
// Local design decisions: the placing of the registers and the strobed register port.
module marker_block_transfer
    import marker_block_transfer_pkg::*;
#(
    parameter int MEM_BYTES = 1024
) (
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [DATA_W-1:0] rdata_o,
    input  wire logic              transfer_trigger_i,
    input  wire logic              enable_i,
    output logic                   count_overflow_error_o,
    output logic                   range_overlap_error_o,
    output logic                   out_of_range_error_o,
    output logic                   busy_o,
    output logic                   transfer_done_o
);

    localparam int MEM_AW = $clog2(MEM_BYTES);

    // Marker byte memory, owned here and shared with the register port
    logic [BYTE_W-1:0] marker_byte [MEM_BYTES];

    // Software-set parameters
    logic              fill_mode;
    src_width_t        src_width;
    logic              enable_required;
    logic [OFF_W-1:0]  source_offset;
    logic [OFF_W-1:0]  dest_offset;
    logic [OFF_W-1:0]  byte_count;

    // Engine state
    xfer_state_t       state;
    xfer_state_t       next_state;
    logic [OFF_W-1:0]  idx;
    logic [BYTE_W-1:0] fill_byte;
    logic              trig_prev;

    // Error flags as registered outputs, and the combinational check results behind them
    logic              err_ovf;
    logic              err_ovl;
    logic              err_oor;
    logic              chk_ovf;
    logic              chk_ovl;
    logic              chk_oor;

    logic [DATA_W-1:0] rdata;
    logic              done;

    // Decoded strobes
    logic              sel_ctrl;
    logic              sel_src;
    logic              sel_dst;
    logic              sel_count;
    logic              sel_status;
    logic              sel_mem;
    logic [ADDR_W-1:0] mem_rel;
    logic [MEM_AW-1:0] bus_idx;
    logic              bus_mem_we;
    logic              param_we;

    // Engine controls
    logic              any_err;
    logic              active;
    logic              trig_rise;
    logic              start;
    logic              last_byte;
    logic              eng_we;
    logic [OFF_W-1:0]  rd_off;
    logic [OFF_W-1:0]  wr_off;
    logic [MEM_AW-1:0] rd_idx;
    logic [MEM_AW-1:0] wr_idx;
    logic [BYTE_W-1:0] rd_byte;
    logic [BYTE_W-1:0] eng_byte;
    logic [DATA_W-1:0] ctrl_word;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] next_rdata;
    logic              busy;

    // Checks run on the live parameters every cycle
    range_check #(
        .MEM_BYTES (MEM_BYTES)
    ) u_check (
        .source_offset_i  (source_offset),
        .dest_offset_i    (dest_offset),
        .byte_count_i     (byte_count),
        .fill_mode_i      (fill_mode),
        .src_width_i      (src_width),
        .count_overflow_o (chk_ovf),
        .range_overlap_o  (chk_ovl),
        .out_of_range_o   (chk_oor)
    );

    // Address decode
    assign mem_rel    = addr_i - MEM_BASE;
    assign sel_ctrl   = (addr_i == CTRL_ADDR);
    assign sel_src    = (addr_i == SRC_ADDR);
    assign sel_dst    = (addr_i == DST_ADDR);
    assign sel_count  = (addr_i == COUNT_ADDR);
    assign sel_status = (addr_i == STATUS_ADDR);
    assign sel_mem    = (addr_i >= MEM_BASE)
                      && ({{(32-ADDR_W){1'b0}}, mem_rel} < MEM_BYTES);
    assign bus_idx    = mem_rel[MEM_AW-1:0];
    assign bus_mem_we = wr_i && sel_mem;
    // Parameters are frozen while a transfer runs
    assign param_we   = wr_i && !busy;

    // Engine controls
    assign busy      = (state != ST_IDLE);
    assign any_err   = chk_ovf || chk_ovl || chk_oor;
    assign active    = !enable_required || enable_i;
    assign trig_rise = transfer_trigger_i && !trig_prev;
    assign start     = trig_rise && active && !any_err
                     && (state == ST_IDLE);
    assign last_byte = (idx == byte_count - ONE_OFF);

    // Byte addresses are offsets from the first marker byte
    assign rd_off = fill_mode ? source_offset
                              : source_offset + idx;
    assign wr_off = dest_offset + idx;
    assign rd_idx = rd_off[MEM_AW-1:0];
    assign wr_idx = wr_off[MEM_AW-1:0];
    assign rd_byte = marker_byte[rd_idx];
    // Lowest byte of the source operand sits at the source offset
    assign eng_byte = fill_mode ? fill_byte : rd_byte;
    // A bus write to memory takes the port; the mover waits that cycle
    assign eng_we = (state == ST_MOVE) && active && !any_err
                  && !bus_mem_we;

    // Readback words
    assign ctrl_word = {{(DATA_W-CTRL_ENREQ_BIT-1){1'b0}},
                        enable_required, src_width, fill_mode};
    assign status_word = {{(DATA_W-STAT_BUSY_BIT-1){1'b0}},
                          busy, err_oor, err_ovl, err_ovf};
    assign next_rdata = !rd_i      ? ZERO_DATA
                      : sel_ctrl   ? ctrl_word
                      : sel_src    ? source_offset
                      : sel_dst    ? dest_offset
                      : sel_count  ? byte_count
                      : sel_status ? status_word
                      : sel_mem    ? {{(DATA_W-BYTE_W){1'b0}},
                                      marker_byte[bus_idx]}
                      : ZERO_DATA;

    // Next engine state
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start) begin
                    next_state = fill_mode ? ST_LOAD : ST_MOVE;
                end
            end
            ST_LOAD: begin
                next_state = (active && !any_err) ? ST_MOVE : ST_IDLE;
            end
            ST_MOVE: begin
                if (!active || any_err) begin
                    next_state = ST_IDLE;
                end else if (eng_we && last_byte) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Engine registers; all cleared at restart, nothing retained
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state     <= ST_IDLE;
            idx       <= ZERO_OFF;
            fill_byte <= ZERO_BYTE;
            trig_prev <= 1'b0;
            done      <= 1'b0;
        end else begin
            state     <= next_state;
            trig_prev <= transfer_trigger_i;
            done      <= eng_we && last_byte;
            if (start) begin
                idx <= ZERO_OFF;
            end else if (eng_we) begin
                idx <= idx + ONE_OFF;
            end
            if (state == ST_LOAD) begin
                fill_byte <= rd_byte;
            end
        end
    end

    // Memory write: one byte per cycle, bus first
    always_ff @(posedge clk_i) begin
        if (bus_mem_we) begin
            marker_byte[bus_idx] <= wdata_i[BYTE_W-1:0];
        end else if (eng_we) begin
            marker_byte[wr_idx] <= eng_byte;
        end
    end

    // Parameter registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fill_mode       <= 1'b0;
            src_width       <= SRC_BYTE;
            enable_required <= 1'b0;
            source_offset   <= ZERO_OFF;
            dest_offset     <= ZERO_OFF;
            byte_count      <= ZERO_OFF;
        end else if (param_we) begin
            if (sel_ctrl) begin
                fill_mode       <= wdata_i[CTRL_MODE_BIT];
                src_width       <= src_width_t'(
                    wdata_i[CTRL_WIDTH_LSB +: 2]);
                enable_required <= wdata_i[CTRL_ENREQ_BIT];
            end
            if (sel_src) begin
                source_offset <= wdata_i;
            end
            if (sel_dst) begin
                dest_offset <= wdata_i;
            end
            if (sel_count) begin
                byte_count <= wdata_i;
            end
        end
    end

    // Error flags follow the checks with one cycle of latency
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            err_ovf <= 1'b0;
            err_ovl <= 1'b0;
            err_oor <= 1'b0;
        end else begin
            err_ovf <= chk_ovf;
            err_ovl <= chk_ovl;
            err_oor <= chk_oor;
        end
    end

    // Read data, valid only in the cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata <= ZERO_DATA;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign rdata_o                = rdata;
    assign count_overflow_error_o = err_ovf;
    assign range_overlap_error_o  = err_ovl;
    assign out_of_range_error_o   = err_oor;
    assign busy_o                 = busy;
    assign transfer_done_o        = done;

endmodule

// [tb/xfer_monitor.sv]
// Port checks of the block transfer engine, one clock domain.
// Assumes it is bound into marker_block_transfer and sees its ports.
module xfer_monitor
    import marker_block_transfer_pkg::*;
(
    input wire logic              clk_i,
    input wire logic              rst_b_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic              wr_i,
    input wire logic              transfer_trigger_i,
    input wire logic              count_overflow_error_o,
    input wire logic              range_overlap_error_o,
    input wire logic              out_of_range_error_o,
    input wire logic              busy_o,
    input wire logic              transfer_done_o
);
    localparam int MAX_BUSY = 800;

    // Error flags as one vector, count writes that are taken
    wire [2:0] errs = {out_of_range_error_o, range_overlap_error_o,
                       count_overflow_error_o};
    wire       count_wr = wr_i && addr_i == COUNT_ADDR && !busy_o;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    // Start of a transfer
    sequence s_start;
        $rose(busy_o);
    endsequence

    a_start_edge: assert property (s_start |->
        $past(transfer_trigger_i) && !$past(transfer_trigger_i, 2))
        else $error("transfer started without a trigger edge");
    a_start_clean: assert property (s_start |-> $past(errs) == 3'h0)
        else $error("transfer started while an error held");
    a_busy_bound: assert property (s_start |-> ##[1:MAX_BUSY] !busy_o)
        else $error("transfer never finished");
    a_done_end: assert property (transfer_done_o |->
        !busy_o && $past(busy_o))
        else $error("done pulse not at end of transfer");
    a_done_pulse: assert property (transfer_done_o |=> !transfer_done_o)
        else $error("done pulse longer than one cycle");
    a_err_cause: assert property ($changed(errs) |->
        $past(wr_i, 2) || !$past(rst_b_i, 2))
        else $error("error flags changed without a write");
    a_zero_count: assert property (count_wr && wdata_i == ZERO_OFF |->
        ##2 out_of_range_error_o)
        else $error("zero count not flagged");
    a_count_ovf: assert property (count_wr |-> ##2
        count_overflow_error_o == ($past(wdata_i, 2) > MAX_COUNT))
        else $error("count overflow flag wrong");
endmodule

bind marker_block_transfer xfer_monitor u_xfer_monitor (
    .clk_i                  (clk_i),
    .rst_b_i                (rst_b_i),
    .addr_i                 (addr_i),
    .wdata_i                (wdata_i),
    .wr_i                   (wr_i),
    .transfer_trigger_i     (transfer_trigger_i),
    .count_overflow_error_o (count_overflow_error_o),
    .range_overlap_error_o  (range_overlap_error_o),
    .out_of_range_error_o   (out_of_range_error_o),
    .busy_o                 (busy_o),
    .transfer_done_o        (transfer_done_o)
);

// [tb/ctrl_master.sv]
// Model of the controlling program: register strobes, trigger, enable.
// Assumes the block never stalls its register port.
module ctrl_master
    import marker_block_transfer_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic [DATA_W-1:0] rdata_i,
    output logic      [ADDR_W-1:0] addr_o,
    output logic      [DATA_W-1:0] wdata_o,
    output logic                   wr_o,
    output logic                   rd_o,
    output logic                   trig_o,
    output logic                   en_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet bus at time zero
    initial begin
        addr_o  = '0;
        wdata_o = '0;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        trig_o  = 1'b0;
        en_o    = 1'b0;
    end

    // One-cycle write; counts are the caller's, error rows break it
    task automatic put(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        wdata_o <= ~d; // No stale data left on the bus
    endtask

    // One-cycle read, data taken in the cycle after
    task automatic get(input logic [ADDR_W-1:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clk_i);
        rd_o   <= 1'b0;
        @(posedge clk_i);
        d = rdata_i;
    endtask

    // Trigger held high for a number of cycles
    task automatic fire(input int hold);
        @(posedge clk_i);
        trig_o <= 1'b1;
        repeat (hold) @(posedge clk_i);
        trig_o <= 1'b0;
    endtask

    // Enable level
    task automatic enable(input logic v);
        @(posedge clk_i);
        en_o <= v;
    endtask
endmodule

// [tb/tb_top.sv]
// Self-checking bench of the marker block transfer engine.
// Assumes the default memory size of 1024 bytes.
module tb_top
    import marker_block_transfer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              clk = 1'b0;
    logic              rst_b = 1'b0;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              wr, rd, trig, en, ovf, ovl, oor, busy, done;
    int                fails, comparisons, dones, cycles;

    marker_block_transfer u_marker_block_transfer (
        .clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .transfer_trigger_i(trig),
        .enable_i(en), .count_overflow_error_o(ovf),
        .range_overlap_error_o(ovl), .out_of_range_error_o(oor),
        .busy_o(busy), .transfer_done_o(done)
    );
    ctrl_master u_ctrl_master (
        .clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd), .trig_o(trig), .en_o(en)
    );

    // Clock, done pulse count and hang limit
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (done === 1'b1)
            dones++;
        if (cycles == 20000) begin
            fails++;
            test_done();
        end
    end

    task automatic check(input logic [15:0] s, e, input string m);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, m, s, e);
        end
    endtask

    task automatic mem_is(input int off, input logic [7:0] e);
        logic [15:0] d;
        u_ctrl_master.get(ADDR_W'(MEM_BASE + off), d);
        check({8'h00, d[7:0]}, {8'h00, e}, "memory byte");
    endtask

    task automatic poke(input int off, input logic [7:0] v);
        u_ctrl_master.put(ADDR_W'(MEM_BASE + off), {8'h00, v});
    endtask

    task automatic prm(input logic [15:0] c, s, d, n);
        u_ctrl_master.put(CTRL_ADDR, c);
        u_ctrl_master.put(SRC_ADDR, s);
        u_ctrl_master.put(DST_ADDR, d);
        u_ctrl_master.put(COUNT_ADDR, n);
    endtask

    // Trigger, then wait out the transfer under a bound
    task automatic go(input int hold);
        int i;
        u_ctrl_master.fire(hold);
        i = 0;
        repeat (2) @(posedge clk);
        while (busy === 1'b1 && i < 500) begin
            @(posedge clk);
            i++;
        end
        repeat (2) @(posedge clk);
    endtask

    task automatic t_reset();
        logic [15:0] d;
        u_ctrl_master.get(STATUS_ADDR, d);
        check(d, 16'h0004, "status after reset");
        check({15'h0, busy}, 16'h0000, "busy after reset");
        u_ctrl_master.get(12'h100, d);
        check(d, 16'h0000, "unmapped read");
        $display("test reset done");
    endtask

    // Copy with the trigger held high: one transfer only
    task automatic t_copy();
        int n;
        for (int i = 0; i < 4; i++)
            poke(i, 8'h10 + 8'(i));
        for (int i = 10; i < 15; i++)
            poke(i, 8'hee);
        prm(16'h0000, 16'h0000, 16'h000a, 16'h0004);
        n = dones;
        go(20);
        check(16'(dones - n), 16'h0001, "one transfer per edge");
        for (int i = 0; i < 4; i++)
            mem_is(10 + i, 8'h10 + 8'(i));
        mem_is(14, 8'hee);
        $display("test copy done");
    endtask

    // Dword fill source: lowest byte only
    task automatic t_fill();
        for (int i = 0; i < 4; i++)
            poke(20 + i, 8'h5a + 8'(i * 17));
        for (int i = 30; i < 36; i++)
            poke(i, 8'hee);
        prm(16'h0005, 16'h0014, 16'h001e, 16'h0005);
        go(1);
        for (int i = 30; i < 35; i++)
            mem_is(i, 8'h5a);
        mem_is(35, 8'hee);
        $display("test fill done");
    endtask

    // Error table: flags, status and suppressed transfers
    task automatic t_errors();
        logic [15:0] d;
        int          n;
        int          s[6] = '{0, 0, 0, 0, 1020, 0};
        int          t[6] = '{500, 600, 1016, 2, 0, 500};
        int          c[6] = '{384, 383, 8, 4, 8, 0};
        logic [2:0]  e[6] = '{3'h1, 3'h0, 3'h0, 3'h2, 3'h4, 3'h4};
        for (int k = 0; k < 6; k++) begin
            prm(16'h0000, 16'(s[k]), 16'(t[k]), 16'(c[k]));
            u_ctrl_master.get(STATUS_ADDR, d);
            check(d, {13'h0, e[k]}, "status flags");
            check({13'h0, oor, ovl, ovf}, {13'h0, e[k]}, "flags");
            n = dones;
            go(1);
            check(16'(dones - n), {15'h0, e[k] == 3'h0}, "transfer");
        end
        mem_is(2, 8'h12);
        $display("test errors done");
    endtask

    // Enable required, then enable ignored
    task automatic t_enable();
        poke(40, 8'hee);
        prm(16'h0008, 16'h0000, 16'h0028, 16'h0002);
        go(1);
        mem_is(40, 8'hee);
        u_ctrl_master.enable(1'b1);
        go(1);
        mem_is(41, 8'h11);
        u_ctrl_master.enable(1'b0);
        prm(16'h0000, 16'h0002, 16'h0032, 16'h0001);
        go(1);
        mem_is(50, 8'h12);
        $display("test enable done");
    endtask

    task automatic test_done();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_copy();
        t_fill();
        t_errors();
        t_enable();
        test_done();
    end
endmodule
